// File: logic/slrf_pkg.sv
/*
 * shared constants and carriers for the receive flow queue block.
 * assumes a 32-bit apb master and a single 50 mhz clock.
 */
`default_nettype none
package slrf_pkg;
    // ==============================================================
    // geometry defaults
    localparam int ADDR_BITS_DEF = 8;
    localparam int DATA_W_DEF = 32;
    localparam int PAUSE_W = 8;
    localparam int CLK_MHZ = 50;

    // ==============================================================
    // register map, byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_THRESH = 8'h04;
    localparam logic [7:0] OFF_PAUSE = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_LEVELS = 8'h10;

    // ctrl fields
    localparam int CTRL_FLOW_EN_BIT = 0;
    localparam logic CTRL_FLOW_EN_RST = 1'b1;
    // threshold and pause count reset values, and the resume count
    localparam logic [15:0] THRESH_RST = 16'h0040;
    localparam logic [PAUSE_W-1:0] PAUSE_RST = 8'hff;
    localparam logic [PAUSE_W-1:0] RESUME_COUNT = 8'h00;

    // status fields
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_REQ_BIT = 2;
    localparam int ST_STATE_LSB = 4;
    // levels fields
    localparam int LV_RD_LSB = 0;
    localparam int LV_WR_LSB = 16;

    // ==============================================================
    // flow engine states
    typedef enum logic [3:0] {
        SLRF_IDLE = 4'b0001,
        SLRF_ASK_HALT = 4'b0010,
        SLRF_HALTED = 4'b0100,
        SLRF_ASK_RESUME = 4'b1000
    } slrf_state_t;

    // ==============================================================
    // apb carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } slrf_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } slrf_apb_rsp_t;
endpackage
`default_nettype wire

// File: logic/slrf_top.sv
/*
 * receive flow queue: stream-to-queue adapter, pause flow engine,
 * word queue and apb register slave, all on one clock.
 * assumes the link core presents one word per cycle while its
 * valid is low and never looks at our accept output.
 */
// Added by the designer: the APB interface to the registers and the placing of the registers.
// Functional notes
// - queue write data is the stream word; write strobe is inverted valid.
// - accept output never follows queue full; no backpressure.
// - only the flow engine keeps the queue from overflowing.
// - engine watches free space and asks for halt, later resume.
// - flow enable low means no new pause or resume request.
// - active-low request held until the core's active-low acknowledge.
// - pause count output accompanies every request.
// - halt requested once free space drops below the threshold.
// - free space fed to the engine is the queue's empty slot count.
// - one word delivered per clock while read strobe is high.
// - one word stored per clock while write strobe is high.
// - vacancy count always valid, full capacity after reset.
// - empty flag updates one cycle before occupancy count.
// - full flag updates one cycle before vacancy count.
// - build option picks fall-through or registered read data.
// - depth from address bits; width and storage kind are parameters.
// - independent clocks option is unused; both sides always follow clk.
// - single clock, active-high reset loads pointers, counts, registers and engine to their reset values, not the word storage.
`timescale 1ns/1ps
`default_nettype none
module slrf_top #(
    parameter int ADDR_BITS = slrf_pkg::ADDR_BITS_DEF,
    parameter int DATA_W = slrf_pkg::DATA_W_DEF,
    parameter bit FALL_THROUGH = 1'b1,
    parameter bit USE_BLOCK_RAM = 1'b0,
    parameter bit INDEPENDENT_CLOCKS = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire slrf_pkg::slrf_apb_req_t apb_req,
    output slrf_pkg::slrf_apb_rsp_t apb_rsp,
    input wire logic stream_source_valid_low,
    input wire logic [DATA_W-1:0] stream_word_in,
    output logic stream_sink_accept_low,
    output logic pause_req_low,
    output logic [slrf_pkg::PAUSE_W-1:0] pause_idle_count,
    input wire logic pause_ack_low,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rd_data,
    output logic rd_empty,
    output logic [ADDR_BITS:0] rd_level,
    output logic wr_full,
    output logic [ADDR_BITS:0] wr_level
);
    localparam int LW = ADDR_BITS + 1;
    localparam int DEPTH = 2 ** ADDR_BITS;
    localparam logic [LW-1:0] CAPACITY = {1'b1, {ADDR_BITS{1'b0}}};

    // ==============================================================
    // adapter
    logic wr_en;
    logic [DATA_W-1:0] wr_data;
    assign wr_data = stream_word_in;
    assign wr_en = ~stream_source_valid_low;
    // always accepting
    // overflow is the flow engine's job, the core ignores this anyway
    assign stream_sink_accept_low = 1'b0;

    // ==============================================================
    // queue storage and pointers
    logic [DATA_W-1:0] mem [DEPTH];
    logic [LW-1:0] wr_ptr_reg;
    logic [LW-1:0] rd_ptr_reg;
    logic [LW-1:0] used;
    logic do_wr;
    logic do_rd;
    logic [LW-1:0] rd_level_reg;
    logic [LW-1:0] wr_level_reg;
    logic [DATA_W-1:0] rd_data_reg;

    assign used = wr_ptr_reg - rd_ptr_reg;
    // flags from pointers, ahead of the counts
    assign rd_empty = (used == '0);
    assign wr_full = (used == CAPACITY);
    assign do_wr = wr_en && !wr_full;
    assign do_rd = rd_en && !rd_empty;

    always_ff @(posedge clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr_reg[ADDR_BITS-1:0]] <= wr_data;
        end
    end

    // common clock build: both sides on clk
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (do_wr)
            begin
                wr_ptr_reg <= wr_ptr_reg + LW'(1);
            end
            if (do_rd)
            begin
                rd_ptr_reg <= rd_ptr_reg + LW'(1);
            end
        end
    end

    // counts lag the flags by one cycle, trading latency for timing
    // occupancy from zero
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rd_level_reg <= '0;
            wr_level_reg <= CAPACITY;
        end
        else
        begin
            rd_level_reg <= used;
            wr_level_reg <= CAPACITY - used;
        end
    end
    assign rd_level = rd_level_reg;
    assign wr_level = wr_level_reg;

    // registered read path
    // block memory output latches cannot be reset, so skip it there
    always_ff @(posedge clk)
    begin
        if (reset && !USE_BLOCK_RAM)
        begin
            rd_data_reg <= '0;
        end
        else if (do_rd)
        begin
            rd_data_reg <= mem[rd_ptr_reg[ADDR_BITS-1:0]];
        end
    end
    // fall-through shows head word before the strobe
    assign rd_data = FALL_THROUGH ? mem[rd_ptr_reg[ADDR_BITS-1:0]]
                                  : rd_data_reg;

    // ==============================================================
    // registers
    logic flow_en_reg;
    logic [LW-1:0] thresh_reg;
    logic [slrf_pkg::PAUSE_W-1:0] pause_len_reg;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic wr_access;
    logic sel_ctrl;
    logic sel_thresh;
    logic sel_pause;
    logic sel_status;
    logic sel_levels;
    logic mapped;
    assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign sel_ctrl = hit(apb_req.paddr, slrf_pkg::OFF_CTRL);
    assign sel_thresh = hit(apb_req.paddr, slrf_pkg::OFF_THRESH);
    assign sel_pause = hit(apb_req.paddr, slrf_pkg::OFF_PAUSE);
    assign sel_status = hit(apb_req.paddr, slrf_pkg::OFF_STATUS);
    assign sel_levels = hit(apb_req.paddr, slrf_pkg::OFF_LEVELS);
    assign mapped = sel_ctrl | sel_thresh | sel_pause | sel_status
                  | sel_levels;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flow_en_reg <= slrf_pkg::CTRL_FLOW_EN_RST;
            thresh_reg <= LW'(slrf_pkg::THRESH_RST);
            pause_len_reg <= slrf_pkg::PAUSE_RST;
        end
        else if (wr_access)
        begin
            if (sel_ctrl)
            begin
                flow_en_reg <= apb_req.pwdata[slrf_pkg::CTRL_FLOW_EN_BIT];
            end
            if (sel_thresh)
            begin
                thresh_reg <= apb_req.pwdata[LW-1:0];
            end
            if (sel_pause)
            begin
                pause_len_reg <= apb_req.pwdata[slrf_pkg::PAUSE_W-1:0];
            end
        end
    end

    // ==============================================================
    // flow engine
    slrf_pkg::slrf_state_t state_reg;
    slrf_pkg::slrf_state_t state_next;
    logic [slrf_pkg::PAUSE_W-1:0] count_reg;
    logic [slrf_pkg::PAUSE_W-1:0] count_next;
    logic [LW-1:0] free_space;
    logic low_space;
    logic acked;

    // free space is the vacancy count
    assign free_space = wr_level_reg;
    assign low_space = (free_space < thresh_reg);
    assign acked = ~pause_ack_low;

    always_comb
    begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            slrf_pkg::SLRF_IDLE:
            begin
                if (flow_en_reg && low_space)
                begin
                    state_next = slrf_pkg::SLRF_ASK_HALT;
                    count_next = pause_len_reg;
                end
            end
            slrf_pkg::SLRF_ASK_HALT:
            begin
                if (acked)
                begin
                    state_next = slrf_pkg::SLRF_HALTED;
                end
            end
            slrf_pkg::SLRF_HALTED:
            begin
                // disabled while halted: drop back without a message
                if (!flow_en_reg)
                begin
                    state_next = slrf_pkg::SLRF_IDLE;
                end
                else if (!low_space)
                begin
                    state_next = slrf_pkg::SLRF_ASK_RESUME;
                    count_next = slrf_pkg::RESUME_COUNT;
                end
            end
            slrf_pkg::SLRF_ASK_RESUME:
            begin
                if (acked)
                begin
                    state_next = slrf_pkg::SLRF_IDLE;
                end
            end
            default:
            begin
                state_next = slrf_pkg::SLRF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_reg <= slrf_pkg::SLRF_IDLE;
            count_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // the request is the only overflow guard
    assign pause_req_low = !((state_reg == slrf_pkg::SLRF_ASK_HALT)
                          || (state_reg == slrf_pkg::SLRF_ASK_RESUME));
    assign pause_idle_count = count_reg;

    // ==============================================================
    // apb read side, zero wait states
    logic [31:0] status_word;
    logic [31:0] levels_word;
    logic [31:0] read_mux;
    assign status_word = {24'h000000, state_reg, 1'b0, ~pause_req_low,
                          wr_full, rd_empty};
    assign levels_word = {16'(wr_level_reg), 16'(rd_level_reg)};
    assign read_mux = sel_ctrl ? {31'h00000000, flow_en_reg}
                    : sel_thresh ? 32'(thresh_reg)
                    : sel_pause ? 32'(pause_len_reg)
                    : sel_status ? status_word
                    : sel_levels ? levels_word
                    : 32'h00000000;
    assign apb_rsp.prdata = read_mux;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;

    // ==============================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_accept_always_on: assert property (stream_sink_accept_low == 1'b0)
        else $error("accept output deasserted");
    a_write_counts: assert property (do_wr && !do_rd |=>
        used == $past(used) + LW'(1))
        else $error("write did not add one word");
    a_read_counts: assert property (do_rd && !do_wr |=>
        used == $past(used) - LW'(1))
        else $error("read did not remove one word");
    a_ignore_bad_access: assert property (rd_empty && !wr_en |=>
        rd_empty)
        else $error("read from empty queue changed state");
    a_level_follows: assert property (1'b1 |=>
        rd_level == $past(used))
        else $error("occupancy count not one cycle behind");
    a_vacancy_sum: assert property (rd_level + wr_level == CAPACITY)
        else $error("occupancy and vacancy disagree");
    a_halt_on_low: assert property (
        state_reg == slrf_pkg::SLRF_IDLE && flow_en_reg && low_space
        |=> !pause_req_low && pause_idle_count == $past(pause_len_reg))
        else $error("low space did not raise a halt request");
    a_hold_until_ack: assert property (
        !pause_req_low && pause_ack_low |=> !pause_req_low)
        else $error("request dropped before acknowledge");
    a_no_req_disabled: assert property (
        state_reg == slrf_pkg::SLRF_IDLE && !flow_en_reg |=> pause_req_low)
        else $error("request raised while disabled");
    a_resume_zero: assert property (
        state_reg == slrf_pkg::SLRF_HALTED && flow_en_reg && !low_space
        |=> !pause_req_low && pause_idle_count == slrf_pkg::RESUME_COUNT)
        else $error("resume missing or count not zero");
    a_count_stable: assert property (
        !pause_req_low && $past(!pause_req_low) |-> $stable(pause_idle_count))
        else $error("pause count changed during request");
    // surplus words are lost silently, so the counts must not move
    a_full_drops_write: assert property (wr_full && !rd_en |=>
        used == $past(used))
        else $error("write into full queue changed state");
    a_release_after_ack: assert property (
        !pause_req_low && !pause_ack_low |=> pause_req_low)
        else $error("request still raised after acknowledge");

    c_full_unguarded: cover property (wr_full && !flow_en_reg);
    c_queue_fills: cover property (wr_full);
    c_halt_acked: cover property (
        state_reg == slrf_pkg::SLRF_ASK_HALT ##1
        state_reg == slrf_pkg::SLRF_HALTED);
    c_resume_done: cover property (
        state_reg == slrf_pkg::SLRF_ASK_RESUME ##1
        state_reg == slrf_pkg::SLRF_IDLE);
endmodule // slrf_top
`default_nettype wire

// File: verification/slrf_link_model.sv
/*
 * link core model: streams words and answers pause requests.
 * assumes the bench supplies the words, a send enable and an ack delay.
 */
`timescale 1ns/1ps
`default_nettype none
module slrf_link_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic send_en,
    input wire logic [31:0] word_src,
    input wire logic [3:0] ack_delay,
    input wire logic pause_req_low,
    input wire logic [7:0] pause_idle_count,
    output logic valid_low,
    output logic [31:0] word,
    output logic ack_low
);
    logic paused_reg;
    logic [3:0] wait_reg;

    // ========================================
    // pause handshake
    // ack when accepted
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ack_low <= 1'b1;
            paused_reg <= 1'b0;
            wait_reg <= 4'h0;
        end
        else if (!ack_low)
            ack_low <= 1'b1;
        else if (!pause_req_low && wait_reg >= ack_delay)
        begin
            ack_low <= 1'b0;
            wait_reg <= 4'h0;
            paused_reg <= (pause_idle_count != 8'h00);
        end
        else if (!pause_req_low)
            wait_reg <= wait_reg + 4'h1;
    end

    // ========================================
    // stream source
    // idle data toggles so a stale word can never pass for a new one
    always_ff @(posedge clk)
    begin
        valid_low <= reset || !send_en || paused_reg;
        word <= reset ? 32'h0 : ((send_en && !paused_reg) ? word_src : ~word);
    end
endmodule // slrf_link_model
`default_nettype wire

// File: verification/serial_link_rx_flow_fifo_tb.sv
/*
 * self-checking bench for the receive flow queue.
 * assumes the package, the top module and the link model are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_link_rx_flow_fifo_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    slrf_pkg::slrf_apb_req_t apb_req = '0;
    slrf_pkg::slrf_apb_rsp_t apb_rsp;
    logic valid_low, accept_low, req_low, ack_low, rd_empty, wr_full, err;
    logic rd_en = 1'b0;
    logic send_en = 1'b0;
    logic [3:0] ack_delay = 4'h3;
    logic [31:0] word_in, rd_data, rdata;
    logic [31:0] rd_data_late, late_exp;
    logic late_due = 1'b0;
    logic [31:0] word_src = 32'h41cbd183;
    logic [31:0] lfsr = 32'h41cbd183;
    logic [7:0] idle_count;
    logic [7:0] pause_len = 8'hff;
    logic [8:0] rd_level, wr_level;
    logic [31:0] exp_q[$];
    logic halted = 1'b0;
    logic flow_on = 1'b1;
    int occ = 0, halts = 0, resumes = 0, rd_mode = 0, o;
    int mismatches = 0, checks = 0;

    always #10 clk = ~clk;

    slrf_top dut_u (.clk(clk), .reset(reset), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .stream_source_valid_low(valid_low),
        .stream_word_in(word_in), .stream_sink_accept_low(accept_low),
        .pause_req_low(req_low), .pause_idle_count(idle_count),
        .pause_ack_low(ack_low), .rd_en(rd_en), .rd_data(rd_data),
        .rd_empty(rd_empty), .rd_level(rd_level), .wr_full(wr_full),
        .wr_level(wr_level));

    // registered read build on the same inputs, checked one cycle later
    slrf_top #(.FALL_THROUGH(1'b0)) dut_reg_u (.clk(clk), .reset(reset),
        .apb_req(apb_req), .apb_rsp(), .stream_source_valid_low(valid_low),
        .stream_word_in(word_in), .stream_sink_accept_low(),
        .pause_req_low(), .pause_idle_count(), .pause_ack_low(ack_low),
        .rd_en(rd_en), .rd_data(rd_data_late), .rd_empty(), .rd_level(),
        .wr_full(), .wr_level());

    slrf_link_model link_u (.clk(clk), .reset(reset), .send_en(send_en),
        .word_src(word_src), .ack_delay(ack_delay), .pause_req_low(req_low),
        .pause_idle_count(idle_count), .valid_low(valid_low),
        .word(word_in), .ack_low(ack_low));

    // ========================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task automatic report_and_stop;
    begin
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
    begin
        @(posedge clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                     pwdata: d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        @(posedge clk);
        while (!apb_rsp.pready)
            @(posedge clk);
        rdata = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    end
    endtask

    task automatic wait_on(input int which);
        int n;
    begin
        n = 0;
        while (n < 3000 && !(which == 0 ? halts > 0 : which == 1 ? resumes > 0
               : which == 2 ? occ == 0 : occ == 256))
        begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        check(n < 3000, 32'h1);
    end
    endtask

    task automatic check_levels;
    begin
        check({23'h0, rd_level}, occ);
        check({23'h0, wr_level}, 256 - occ);
        check({30'h0, rd_empty, wr_full}, {occ == 0, occ == 256});
        check({31'h0, accept_low}, 32'h0);
    end
    endtask

    // ========================================
    // stimulus and scoreboard
    // one process so the read pop and the write note never race
    always @(posedge clk)
    begin
        lfsr = lfsr_next(lfsr);
        word_src <= lfsr;
        rd_en <= (rd_mode == 2) || (rd_mode == 1 && lfsr[3]);
        o = occ;
        if (reset)
        begin
            occ = 0;
            late_due = 1'b0;
            exp_q.delete();
        end
        else
        begin
            if (late_due)
                check(rd_data_late, late_exp);
            late_due = 1'b0;
            if (rd_en && o > 0)
            begin
                late_exp = exp_q.pop_front();
                check(rd_data, late_exp);
                late_due = 1'b1;
                occ--;
            end
            if (!valid_low && o < 256)
            begin
                exp_q.push_back(word_in);
                occ++;
            end
        end
    end

    // ========================================
    // pause request watch
    always @(posedge clk)
    begin
        if (reset)
            halted = 1'b0;
        else if (!req_low)
        begin
            check(idle_count, halted ? 32'h0 : pause_len);
            check({31'h0, flow_on}, 32'h1);
            if (!ack_low)
            begin
                halts += !halted;
                resumes += halted;
                halted = !halted;
            end
        end
    end

    // ========================================
    // main sequence
    logic [7:0] addrs [6] = '{slrf_pkg::OFF_CTRL, slrf_pkg::OFF_THRESH,
        slrf_pkg::OFF_PAUSE, slrf_pkg::OFF_STATUS, slrf_pkg::OFF_LEVELS,
        8'h14};
    logic [31:0] vals [6] = '{32'h1, 32'h40, 32'hff, 32'h11, 32'h0100_0000,
        32'h0};

    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        check_levels();
        check({31'h0, req_low}, 32'h1);
        foreach (addrs[i])
        begin
            apb(1'b0, addrs[i], 32'h0);
            check(rdata, vals[i]);
            check({31'h0, err}, i == 5);
        end
        apb(1'b1, slrf_pkg::OFF_PAUSE, 32'h20);
        pause_len = 8'h20;
        apb(1'b0, slrf_pkg::OFF_PAUSE, 32'h0);
        check(rdata, 32'h20);
        send_en <= 1'b1;
        wait_on(0);
        repeat (10) @(posedge clk);
        check_levels();
        check({31'h0, wr_level < 9'h040}, 32'h1);
        // halted, request released, queue neither empty nor full
        apb(1'b0, slrf_pkg::OFF_STATUS, 32'h0);
        check(rdata, 32'h40);
        rd_mode = 1;
        wait_on(1);
        send_en <= 1'b0;
        rd_mode = 2;
        wait_on(2);
        repeat (6) @(posedge clk);
        check_levels();
        rd_mode = 0;
        // flow off: the queue must drop the surplus on its own
        flow_on = 1'b0;
        apb(1'b1, slrf_pkg::OFF_CTRL, 32'h0);
        send_en <= 1'b1;
        wait_on(3);
        repeat (30) @(posedge clk);
        check_levels();
        send_en <= 1'b0;
        rd_mode = 2;
        wait_on(2);
        check_levels();
        report_and_stop();
    end

    // ========================================
    // watchdog
    initial
    begin
        #(20 * 20000);
        mismatches++;
        report_and_stop();
    end
endmodule // serial_link_rx_flow_fifo_tb
`default_nettype wire
